// ==== sim/legacy_opcode_reuse_decode_tb.sv ====
// Purpose: Self-checking bench for the legacy opcode reuse decoder.
// Assumes: Answers arrive one cycle after each word, in order.
// Notes:   A reduced instance decodes the same words beside the full one.
`timescale 1ns/1ps
`default_nettype none
module legacy_opcode_reuse_decode_tb;
  import lord_pkg::*;
  logic ref_clk, rst, gap_en, fetch_valid, dec_valid, dec_added, red_valid;
  logic [31:0] fetch_word;
  logic [4:0] dec_reg1;
  logic [5:0] dec_imm6;
  lord_op_t dec_op, red_op, e;
  logic [31:0] exp_w[$];
  lord_op_t exp_op[$];
  int miscompares = 0;
  int compares = 0;
  lord_fetch_model i_fetch (.ref_clk(ref_clk), .rst(rst), .gap_en(gap_en),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  lord_decode #(.REDUCED(1'b0)) i_dut (.ref_clk(ref_clk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .dec_valid(dec_valid), .dec_op(dec_op), .dec_reg1(dec_reg1),
    .dec_imm6(dec_imm6), .dec_added(dec_added));
  lord_decode #(.REDUCED(1'b1)) i_red (.ref_clk(ref_clk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .dec_valid(red_valid), .dec_op(red_op), .dec_reg1(),
    .dec_imm6(), .dec_added());
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] mk(logic [4:0] r2, logic [5:0] opc, logic [4:0] r1,
                                     logic [15:0] hi);
    return {hi, r2, opc, r1};
  endfunction
  function automatic logic [31:0] ex(logic [5:0] sub, logic [1:0] s);
    return {5'h03, sub, 2'h0, s, 1'b0, 5'h04, OPC_EXT1, 5'h06};
  endfunction
  task automatic send(input logic [31:0] w, input lord_op_t op);
    exp_w.push_back(w);
    exp_op.push_back(op);
    i_fetch.push(w);
  endtask
  task automatic chk_op(input lord_op_t got, input lord_op_t want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("ERROR %0t class %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic chk_fld(input logic [11:0] got, input logic [11:0] want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("ERROR %0t fields %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // Result watcher: outputs are settled at the falling edge.
  always @(negedge ref_clk) begin
    if (dec_valid === 1'b1 && exp_w.size() == 0) begin
      miscompares++;
      $display("ERROR %0t answer without a word", $time);
    end else if (dec_valid === 1'b1) begin
      e = exp_op.pop_front();
      chk_op(dec_op, e);
      chk_fld({dec_added, dec_reg1, dec_imm6}, {e != LORD_OP_LEGACY, exp_w[0][4:0],
        exp_w[0][5:0]});
      chk_op(red_op, (e == LORD_OP_DEBUG_TRAP || e == LORD_OP_DEBUG_RETURN)
        ? LORD_OP_ILLEGAL : e);
      chk_fld({11'h000, red_valid}, 12'h001);
      void'(exp_w.pop_front());
    end
  end
  initial begin
    #(50 * 20000);
    miscompares++;
    final_report();
  end
  initial begin
    logic [31:0] w;
    rst = 1'b1;
    gap_en = 1'b0;
    void'($urandom(79068));
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    send(mk(5'h00, OPC_MOV_I5, 5'h15, 16'h0000), LORD_OP_TABLE_CALL);
    send(mk(5'h00, OPC_SATURATING_ADD_I5, 5'h0A, 16'h0000), LORD_OP_TABLE_CALL);
    send(mk(5'h00, OPC_MOVE_HIGH_IMMEDIATE, 5'h07, 16'h1220), LORD_OP_FRAME_REL);
    send(mk(5'h00, OPC_SATURATING_SUB_IMMEDIATE, 5'h00, 16'h0007), LORD_OP_FRAME_REL_JMP);
    send(mk(5'h00, OPC_MOVE_ADD_IMMEDIATE, 5'h1F, 16'hFFFF), LORD_OP_MOV_IMM32);
    send(mk(5'h00, OPC_HALFWORD_DIVIDE_R, 5'h03, 16'h0000), LORD_OP_TABLE_BRANCH);
    send(mk(5'h00, OPC_SATURATING_SUBTRACT_R, 5'h01, 16'h0000), LORD_OP_SEXT_BYTE);
    send(mk(5'h00, OPC_HALFWORD_MULTIPLY_R, 5'h02, 16'h0000), LORD_OP_SEXT_HALF);
    send(mk(5'h00, OPC_SATURATING_REVERSE_SUBTRACT_R, 5'h04, 16'h0000), LORD_OP_ZEXT_BYTE);
    send(mk(5'h00, OPC_SATURATING_ADD_R, 5'h05, 16'h0000), LORD_OP_ZEXT_HALF);
    send(mk(5'h00, OPC_HALFWORD_MULTIPLY_I5, 5'h06, 16'h0000), LORD_OP_RESERVED);
    send(mk(5'h00, OPC_HALFWORD_MULTIPLY_IMMEDIATE, 5'h08, 16'h0000), LORD_OP_RESERVED);
    send(mk(5'h02, OPC_MOV_I5, 5'h01, 16'h0000), LORD_OP_LEGACY);
    send(mk(5'h1F, OPC_HALFWORD_MULTIPLY_R, 5'h01, 16'h0000), LORD_OP_LEGACY);
    send(ex(SUB_SWAP, 2'h0), LORD_OP_SWAP_BW);
    send(ex(SUB_SWAP, 2'h1), LORD_OP_SWAP_BH);
    send(ex(SUB_SWAP, 2'h2), LORD_OP_SWAP_HW);
    send(ex(SUB_CONDITIONAL_MOVE_R, 2'h0), LORD_OP_CONDITIONAL_MOVE);
    send(ex(SUB_MUL_I, 2'h1), LORD_OP_MUL3);
    send(ex(SUB_DIV, 2'h1), LORD_OP_DIVIDE);
    send(ex(SUB_RET, 2'h2), LORD_OP_TC_RETURN);
    send(ex(SUB_SHIFT_AND_SET_FLAG, 2'h0), LORD_OP_SHIFT_SET);
    for (int s = 0; s < 4; s++) send(ex(SUB_BITM2, s[1:0]), LORD_OP_BIT_REG);
    send(ex(SUB_RET, 2'h3), LORD_OP_DEBUG_RETURN);
    send(mk(5'h00, OPC_HALFWORD_DIVIDE_R, 5'h00, 16'h0000), LORD_OP_DEBUG_TRAP);
    send(mk(5'h02, OPC_LDU_A, 5'h01, 16'h0001), LORD_OP_LOAD_BU);
    send(mk(5'h02, OPC_LDU_B, 5'h01, 16'h0001), LORD_OP_LOAD_HU);
    send(mk(5'h04, OPC_SLD_BHU, 5'h05, 16'h0000), LORD_OP_SLOAD_BU);
    send(mk(5'h04, OPC_SLD_BHU, 5'h15, 16'h0000), LORD_OP_SLOAD_HU);
    send(mk(5'h00, OPC_LDU_A, 5'h01, 16'h0001), LORD_OP_FRAME_SETUP);
    send(mk(5'h02, {OPC_LDU_A[5:1], 1'b0}, 5'h01, 16'h0001), LORD_OP_LOAD_BU);
    send(mk(5'h00, {OPC_LDU_A[5:1], 1'b0}, 5'h01, 16'h0001), LORD_OP_FRAME_SETUP);
    send(ex(6'h0F, 2'h0), LORD_OP_LEGACY);
    send(ex(6'h21, 2'h0), LORD_OP_ILLEGAL);
    repeat (40) @(posedge ref_clk);
    #1 gap_en = 1'b1;
    for (int i = 0; i < 120; i++) begin
      w = $urandom;
      w[10:5] = (i % 2 == 0) ? 6'h08 + 6'($urandom_range(7, 0)) : OPC_MOV_I5;
      if (i % 2 == 1) w[15:11] = 5'h00;
      send(w, (i % 2 == 0) ? LORD_OP_LEGACY : LORD_OP_TABLE_CALL);
    end
    for (int i = 0; i < 3000 && exp_w.size() > 0; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    if (exp_w.size() > 0) miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

// ==== sim/lord_decode_monitor.sv ====
// Purpose: Concurrent checks on the decoder's ports.
// Assumes: One clock; every answer is registered one cycle after the word.
// Notes:   Bound to every decoder instance, full and reduced alike.
`timescale 1ns/1ps
`default_nettype none
module lord_decode_monitor
  import lord_pkg::*;
#(
  parameter bit REDUCED = 1'b0
) (
  // Clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst,
  // Fetch side
  input wire logic                        fetch_valid,
  input wire logic [lord_pkg::WORD_W-1:0] fetch_word,
  // Execution side
  input wire logic                        dec_valid,
  input wire lord_pkg::lord_op_t          dec_op,
  input wire logic [lord_pkg::REG_W-1:0]  dec_reg1,
  input wire logic [lord_pkg::IMM6_W-1:0] dec_imm6,
  input wire logic                        dec_added
);
  // ==========================================================================
  // Field decode
  wire logic [5:0] opc = fetch_word[10:5];
  wire logic       r2z = fetch_word[15:11] == 5'h00;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_call;
    fetch_valid && r2z && (opc == OPC_MOV_I5 || opc == OPC_SATURATING_ADD_I5);
  endsequence
  sequence s_frame;
    fetch_valid && r2z && (opc == OPC_MOVE_HIGH_IMMEDIATE || opc == OPC_SATURATING_SUB_IMMEDIATE);
  endsequence
  a_valid_follows: assert property (fetch_valid |=> dec_valid)
    else $error("No answer one cycle after a fetched word.");
  a_idle_quiet: assert property (!fetch_valid |=> !dec_valid)
    else $error("Answer without a fetched word.");
  a_added_flag: assert property (dec_valid |-> dec_added == (dec_op != LORD_OP_LEGACY))
    else $error("Added flag disagrees with the class.");
  a_reg1_copy: assert property (fetch_valid |=> dec_reg1 == $past(fetch_word[4:0]))
    else $error("Source register field not carried.");
  a_table_call: assert property (
    s_call |=> dec_op == LORD_OP_TABLE_CALL && dec_imm6 == $past(fetch_word[5:0]))
    else $error("Table call not decoded.");
  a_frame_release: assert property (
    s_frame |=> dec_op == (($past(fetch_word[20:16]) == 5'h00)
      ? LORD_OP_FRAME_REL : LORD_OP_FRAME_REL_JMP))
    else $error("Frame release not decoded.");
  a_imm32_move: assert property (
    fetch_valid && r2z && opc == OPC_MOVE_ADD_IMMEDIATE |=> dec_op == LORD_OP_MOV_IMM32)
    else $error("Wide immediate move not decoded.");
  a_reserved_codes: assert property (
    fetch_valid && r2z && (opc == OPC_HALFWORD_MULTIPLY_I5 || opc == OPC_HALFWORD_MULTIPLY_IMMEDIATE)
      |=> dec_op == LORD_OP_RESERVED)
    else $error("Reserved code not marked.");
  a_legacy_kept: assert property (
    fetch_valid && !r2z && (opc == OPC_MOV_I5 || opc == OPC_MOVE_ADD_IMMEDIATE || opc == OPC_HALFWORD_MULTIPLY_R)
      |=> dec_op == LORD_OP_LEGACY)
    else $error("Older meaning lost.");
  a_no_debug: assert property (
    REDUCED && dec_valid |-> dec_op != LORD_OP_DEBUG_TRAP && dec_op != LORD_OP_DEBUG_RETURN)
    else $error("Debug operation in reduced variant.");
endmodule
bind lord_decode lord_decode_monitor #(.REDUCED(REDUCED)) i_mon (.ref_clk(ref_clk), .rst(rst),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word), .dec_valid(dec_valid), .dec_op(dec_op),
  .dec_reg1(dec_reg1), .dec_imm6(dec_imm6), .dec_added(dec_added));
`default_nettype wire

// ==== sim/lord_fetch_model.sv ====
// Purpose: Fetch stage model that streams whole words to the decoder.
// Assumes: Words are queued by the bench through push.
// Notes:   Idle cycles invert the word so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module lord_fetch_model (
  // Clock and control
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        gap_en,
  // To the decoder
  output var  logic        fetch_valid,
  output var  logic [31:0] fetch_word
);
  logic [31:0] pend[$];
  task automatic push(input logic [31:0] w);
    pend.push_back(w);
  endtask
  // ==========================================================================
  // Streaming, with random stalls when asked.
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 32'h00000000;
    forever begin
      @(posedge ref_clk);
      #1;
      if (!rst && pend.size() > 0 && !(gap_en && $urandom_range(1, 0) == 0)) begin
        fetch_valid = 1'b1;
        fetch_word  = pend.pop_front();
      end else begin
        fetch_valid = 1'b0;
        fetch_word  = ~fetch_word;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/lord_decode.sv ====
// Function
// - Older-core words keep their meaning except the reassigned code points.
// - Pure zero-register writes decode as the added operations instead.
// - Short move or saturating add immediate to r0 becomes table_call imm6.
// - Move-high or saturating-sub immediate to r0 becomes frame_release.
// - Move-add immediate to r0 becomes a 32-bit immediate move.
// - Halfword divide register to r0 becomes the table branch unless reg1 is also r0.
// - Saturating subtract register to r0 becomes sign_extend_byte.
// - Halfword multiply register to r0 becomes sign_extend_half.
// - Saturating reverse subtract register to r0 becomes zero_extend_byte.
// - Saturating add register to r0 becomes zero_extend_half.
// - Halfword multiply immediates to r0 are reserved_future.
// - Formerly illegal codes give swaps, conditional_move, multiplies, divides, return, shift-set.
// - Formerly undefined codes give bit ops, debug ops, unsigned loads, frame_setup.
//
// Purpose: Classify fetched opcode words, marking codes reused from the older core.
// Assumes: Fetch supplies one whole word per valid cycle, halfword 0 in bits 15:0.
// Notes:   Answer is registered, one cycle after the word is taken.
`timescale 1ns/1ps
`default_nettype none
module lord_decode #(
  parameter bit REDUCED = 1'b0
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // From fetch
  input  wire logic                          fetch_valid,
  input  wire logic [lord_pkg::WORD_W-1:0]   fetch_word,
  // To execution
  output var  logic                          dec_valid,
  output var  lord_pkg::lord_op_t            dec_op,
  output var  logic [lord_pkg::REG_W-1:0]    dec_reg1,
  output var  logic [lord_pkg::IMM6_W-1:0]   dec_imm6,
  output var  logic                          dec_added
);
  import lord_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // The output slot is packed by hand, so the field widths must stay as below.
  if (OPC_W != 6 || REG_W != 5 || IMM6_W != 6 || SUB_W != 6) begin : g_bad_widths
    $error("Field widths do not fit the packed output slot.");
  end

  // ==========================================================================
  // Register-field test
  // Most reused codes were writes to r0, so this test recurs throughout.
  function automatic logic zero_reg(input logic [4:0] f);
    return (f == 5'h00);
  endfunction

  // ==========================================================================
  // Field extraction
  wire logic [5:0] opc   = fetch_word[OPC_LSB +: OPC_W];
  wire logic [4:0] reg1  = fetch_word[REG1_LSB +: REG_W];
  wire logic [4:0] reg2  = fetch_word[REG2_LSB +: REG_W];
  wire logic [5:0] sub   = fetch_word[SUB_LSB +: SUB_W];
  wire logic       r2z   = zero_reg(reg2);
  wire logic       r1z   = zero_reg(reg1);
  wire logic       b4    = fetch_word[4];
  wire logic       b16   = fetch_word[16];
  wire logic       b17   = fetch_word[17];
  wire logic       b18   = fetch_word[18];
  // Bit 16 low selects the expansion space; high on this opcode is a load unless reg2 is r0.
  wire logic       ext   = (opc == OPC_EXT1) && fetch_word[16] == 1'b0;
  // The release jump register sits in the second halfword, not in bits 4:0.
  wire logic       jz    = zero_reg(fetch_word[JREG_LSB +: REG_W]);
  // Byte loads and frame setup own both codes, bit 5 being a displacement bit.
  wire logic       ldbu  = (opc[5:1] == OPC_LDU_A[5:1]);

  // ==========================================================================
  // Second-level tables of the expansion space
  function automatic lord_op_t ret_decode(input logic h17, input logic h18, input logic red);
    lord_op_t r;
    r = LORD_OP_LEGACY;
    if (h18 && !h17) begin
      r = LORD_OP_TC_RETURN;
    end else if (h18 && h17) begin
      r = red ? LORD_OP_ILLEGAL : LORD_OP_DEBUG_RETURN;
    end
    return r;
  endfunction

  function automatic lord_op_t swap_decode(input logic h17, input logic h18);
    lord_op_t r;
    r = LORD_OP_SWAP_BW;
    if (h18) begin
      r = h17 ? LORD_OP_ILLEGAL : LORD_OP_SWAP_HW;
    end else if (h17) begin
      r = LORD_OP_SWAP_BH;
    end
    return r;
  endfunction

  // ==========================================================================
  // Sub-opcode decode of the expansion space
  function automatic lord_op_t ext_decode(input logic [5:0] s, input logic h17,
                                          input logic h18, input logic red);
    lord_op_t r;
    r = LORD_OP_LEGACY;
    if (s[5]) begin
      r = LORD_OP_ILLEGAL;
    end else begin
      unique case (s)
        SUB_BITM2:             r = LORD_OP_BIT_REG;
        SUB_RET:               r = ret_decode(h17, h18, red);
        SUB_SHIFT_AND_SET_FLAG:              r = LORD_OP_SHIFT_SET;
        SUB_MUL_R, SUB_MUL_I, SUB_MUL_I2: r = LORD_OP_MUL3;
        SUB_HALFWORD_DIVIDE, SUB_DIV:     r = LORD_OP_DIVIDE;
        SUB_CONDITIONAL_MOVE_I, SUB_CONDITIONAL_MOVE_R: r = LORD_OP_CONDITIONAL_MOVE;
        SUB_SWAP:              r = swap_decode(h17, h18);
        // Undefined rows keep the older core's handling.
        default:               r = LORD_OP_LEGACY;
      endcase
    end
    return r;
  endfunction

  // ==========================================================================
  // Reused code points
  // table call
  wire logic hit_tcall  = r2z && (opc == OPC_MOV_I5 || opc == OPC_SATURATING_ADD_I5);
  wire logic hit_frel   = r2z && (opc == OPC_MOVE_HIGH_IMMEDIATE || opc == OPC_SATURATING_SUB_IMMEDIATE);
  wire logic hit_mov32  = r2z && (opc == OPC_MOVE_ADD_IMMEDIATE);
  wire logic hit_tbr    = r2z && !r1z && (opc == OPC_HALFWORD_DIVIDE_R);
  wire logic hit_dtrap  = r2z && r1z && (opc == OPC_HALFWORD_DIVIDE_R);
  wire logic hit_sxb    = r2z && (opc == OPC_SATURATING_SUBTRACT_R);
  wire logic hit_sxh    = r2z && (opc == OPC_HALFWORD_MULTIPLY_R);
  wire logic hit_zxb    = r2z && (opc == OPC_SATURATING_REVERSE_SUBTRACT_R);
  wire logic hit_zxh    = r2z && (opc == OPC_SATURATING_ADD_R);
  wire logic hit_rfu    = r2z && (opc == OPC_HALFWORD_MULTIPLY_I5 || opc == OPC_HALFWORD_MULTIPLY_IMMEDIATE);
  wire logic hit_sld    = !r2z && (opc == OPC_SLD_BHU);
  wire logic hit_ldu    = b16 && !r2z && (ldbu || opc == OPC_LDU_B);
  wire logic hit_fset   = b16 && r2z && ldbu;
  wire lord_op_t ext_op = ext_decode(sub, b17, b18, REDUCED);

  // ==========================================================================
  // Priority selection
  lord_op_t next_op;
  // Each hit is keyed on its own opcode, bit 16 or register test, so no two hits can fire together;
  // a chain reads closer to the code tables than a one-hot mux would.
  // zero-register reuse, then loads and the expansion space
  always_comb begin
    next_op = LORD_OP_LEGACY;
    if (hit_tcall) begin
      next_op = LORD_OP_TABLE_CALL;
    end else if (hit_frel) begin
      next_op = jz ? LORD_OP_FRAME_REL : LORD_OP_FRAME_REL_JMP;
    end else if (hit_mov32) begin
      next_op = LORD_OP_MOV_IMM32;
    end else if (hit_tbr) begin
      next_op = LORD_OP_TABLE_BRANCH;
    end else if (hit_dtrap) begin
      next_op = REDUCED ? LORD_OP_ILLEGAL : LORD_OP_DEBUG_TRAP;
    end else if (hit_sxb) begin
      next_op = LORD_OP_SEXT_BYTE;
    end else if (hit_sxh) begin
      next_op = LORD_OP_SEXT_HALF;
    end else if (hit_zxb) begin
      next_op = LORD_OP_ZEXT_BYTE;
    end else if (hit_zxh) begin
      next_op = LORD_OP_ZEXT_HALF;
    end else if (hit_rfu) begin
      next_op = LORD_OP_RESERVED;
    end else if (hit_sld) begin
      next_op = b4 ? LORD_OP_SLOAD_HU : LORD_OP_SLOAD_BU;
    end else if (hit_fset) begin
      next_op = LORD_OP_FRAME_SETUP;
    end else if (hit_ldu) begin
      next_op = ldbu ? LORD_OP_LOAD_BU : LORD_OP_LOAD_HU;
    end else if (ext) begin
      next_op = ext_op;
    end
  end

  wire logic       next_added = (next_op != LORD_OP_LEGACY);
  // The table call index spans bits 5:0 since the old imm5 plus opcode bit 5 merge.
  wire logic [5:0] next_imm6  = fetch_word[5:0];

  // ==========================================================================
  // Output register
  // A stage of its own keeps every output straight from a flip-flop.
  // Slot layout, high to low: class, source register, table index, added flag.
  localparam int unsigned SLOT_W = OPC_W + REG_W + IMM6_W + 1;
  wire logic [SLOT_W-1:0] slot_in = {6'(next_op), reg1, next_imm6, next_added};
  wire logic [SLOT_W-1:0] slot_out;
  wire logic              slot_v;

  lord_stage #(.DW(SLOT_W)) u_stage (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fetch_valid),
    .in_data   (slot_in),
    .out_valid (slot_v),
    .out_data  (slot_out)
  );

  always_comb begin
    dec_valid = slot_v;
    dec_op    = lord_op_t'(slot_out[17:12]);
    dec_reg1  = slot_out[11:7];
    dec_imm6  = slot_out[6:1];
    dec_added = slot_out[0];
  end

endmodule
`default_nettype wire

// ==== src/lord_pkg.sv ====
// Purpose: Shared constants and types for the legacy opcode reuse decoder.
// Assumes: 32-bit opcode words, halfword 0 in bits 15:0, halfword 1 in bits 31:16.
// Notes:   Opcode field values follow the core's opcode map.
package lord_pkg;

  // ==========================================================================
  // Field widths
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned OPC_W    = 6;
  localparam int unsigned REG_W    = 5;
  localparam int unsigned IMM6_W   = 6;

  // ==========================================================================
  // Field positions
  localparam int unsigned OPC_LSB  = 5;
  localparam int unsigned REG2_LSB = 11;
  localparam int unsigned REG1_LSB = 0;
  localparam int unsigned SUB_LSB  = 21;
  localparam int unsigned SUB_W    = 6;
  localparam int unsigned JREG_LSB = 16;

  // ==========================================================================
  // Major opcodes, bits 10:5
  localparam logic [5:0] OPC_MOV_R      = 6'h00;
  localparam logic [5:0] OPC_HALFWORD_DIVIDE_R     = 6'h02;
  localparam logic [5:0] OPC_SLD_BHU    = 6'h03;
  localparam logic [5:0] OPC_SATURATING_REVERSE_SUBTRACT_R  = 6'h04;
  localparam logic [5:0] OPC_SATURATING_SUBTRACT_R   = 6'h05;
  localparam logic [5:0] OPC_SATURATING_ADD_R   = 6'h06;
  localparam logic [5:0] OPC_HALFWORD_MULTIPLY_R     = 6'h07;
  localparam logic [5:0] OPC_MOV_I5     = 6'h10;
  localparam logic [5:0] OPC_SATURATING_ADD_I5  = 6'h11;
  localparam logic [5:0] OPC_HALFWORD_MULTIPLY_I5    = 6'h17;
  localparam logic [5:0] OPC_MOVE_ADD_IMMEDIATE      = 6'h31;
  localparam logic [5:0] OPC_MOVE_HIGH_IMMEDIATE      = 6'h32;
  localparam logic [5:0] OPC_SATURATING_SUB_IMMEDIATE    = 6'h33;
  localparam logic [5:0] OPC_HALFWORD_MULTIPLY_IMMEDIATE      = 6'h37;
  localparam logic [5:0] OPC_BITM1      = 6'h3E;
  localparam logic [5:0] OPC_LDU_A      = 6'h3D;
  localparam logic [5:0] OPC_LDU_B      = 6'h3F;
  localparam logic [5:0] OPC_EXT1       = 6'h3F;

  // ==========================================================================
  // Expansion sub-opcodes, bits 26:21
  localparam logic [5:0] SUB_BITM2      = 6'h07;
  localparam logic [5:0] SUB_RET        = 6'h0A;
  localparam logic [5:0] SUB_SHIFT_AND_SET_FLAG       = 6'h10;
  localparam logic [5:0] SUB_MUL_R      = 6'h11;
  localparam logic [5:0] SUB_MUL_I      = 6'h12;
  localparam logic [5:0] SUB_MUL_I2     = 6'h13;
  localparam logic [5:0] SUB_HALFWORD_DIVIDE       = 6'h14;
  localparam logic [5:0] SUB_DIV        = 6'h16;
  localparam logic [5:0] SUB_CONDITIONAL_MOVE_I     = 6'h18;
  localparam logic [5:0] SUB_CONDITIONAL_MOVE_R     = 6'h19;
  localparam logic [5:0] SUB_SWAP       = 6'h1A;

  // ==========================================================================
  // Decoded operation classes
  typedef enum logic [5:0] {
    LORD_OP_LEGACY        = 6'h00,
    LORD_OP_TABLE_CALL    = 6'h01,
    LORD_OP_FRAME_REL     = 6'h02,
    LORD_OP_FRAME_REL_JMP = 6'h03,
    LORD_OP_MOV_IMM32     = 6'h04,
    LORD_OP_TABLE_BRANCH  = 6'h05,
    LORD_OP_SEXT_BYTE     = 6'h06,
    LORD_OP_SEXT_HALF     = 6'h07,
    LORD_OP_ZEXT_BYTE     = 6'h08,
    LORD_OP_ZEXT_HALF     = 6'h09,
    LORD_OP_RESERVED      = 6'h0A,
    LORD_OP_SWAP_BH       = 6'h0B,
    LORD_OP_SWAP_BW       = 6'h0C,
    LORD_OP_SWAP_HW       = 6'h0D,
    LORD_OP_CONDITIONAL_MOVE          = 6'h0E,
    LORD_OP_MUL3          = 6'h0F,
    LORD_OP_DIVIDE        = 6'h10,
    LORD_OP_TC_RETURN     = 6'h11,
    LORD_OP_SHIFT_SET     = 6'h12,
    LORD_OP_BIT_REG       = 6'h13,
    LORD_OP_DEBUG_RETURN  = 6'h14,
    LORD_OP_DEBUG_TRAP    = 6'h15,
    LORD_OP_LOAD_BU       = 6'h16,
    LORD_OP_LOAD_HU       = 6'h17,
    LORD_OP_SLOAD_BU      = 6'h18,
    LORD_OP_SLOAD_HU      = 6'h19,
    LORD_OP_FRAME_SETUP   = 6'h1A,
    LORD_OP_ILLEGAL       = 6'h1B
  } lord_op_t;

endpackage

// ==== src/lord_stage.sv ====
// Purpose: One pipeline register slot carrying a decoded operation.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Keeps the top's outputs straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module lord_stage #(
  parameter int unsigned DW = 32
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Slot input
  input  wire logic          in_valid,
  input  wire logic [DW-1:0] in_data,
  // Slot output
  output var  logic          out_valid,
  output var  logic [DW-1:0] out_data
);

  // ==========================================================================
  // Storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid;
      out_data  <= in_data;
    end
  end

endmodule
`default_nettype wire
